/* File: bus_status_pkg.sv */
// Package for the two-channel two-wire bus status flag block.
// Assumes a 32-bit Avalon-MM slave port with word-aligned registers.
package bus_status_pkg;

   // ==========================================================
   // Register map (byte addresses)
   localparam logic [5:0] OFS_STATUS_CH0  = 6'h00;
   localparam logic [5:0] OFS_STATUS_CH1  = 6'h04;
   localparam logic [5:0] OFS_CTRL_CH0    = 6'h08;
   localparam logic [5:0] OFS_CTRL_CH1    = 6'h0c;
   localparam logic [5:0] OFS_SADDR_CH0   = 6'h10;
   localparam logic [5:0] OFS_SADDR_CH1   = 6'h14;
   localparam logic [5:0] OFS_BITREAD     = 6'h18;
   localparam logic [5:0] OFS_IRQ_STATUS  = 6'h1c;
   localparam logic [5:0] OFS_IRQ_MASK    = 6'h20;

   // ==========================================================
   // Status byte layout
   localparam int BIT_MASTER   = 7;
   localparam int BIT_ARBLOST  = 6;
   localparam int BIT_EXTCODE  = 5;
   localparam int BIT_ADDRMAT  = 4;
   localparam int BIT_TXDIR    = 3;
   localparam int BIT_ACKDET   = 2;
   localparam int BIT_STARTDET = 1;
   localparam int BIT_STOPDET  = 0;

   // Control register layout
   localparam int CTL_ENABLE   = 0;
   localparam int CTL_START    = 1;
   localparam int CTL_EXIT     = 2;

   // Bit-read register: [2:0] bit index, [3] channel
   localparam int BR_CH        = 3;

   // Interrupt status layout (per channel base = 2*ch)
   localparam int IRQ_ARBLOST  = 0;
   localparam int IRQ_ADDRMAT  = 1;

   // ==========================================================
   // Reset values
   localparam logic [7:0] STATUS_RST = 8'h00;
   localparam logic [7:0] CTRL_RST   = 8'h00;
   localparam logic [7:0] SADDR_RST  = 8'h00;
   localparam logic [3:0] IRQ_RST    = 4'h0;

   // Upper nibble values that mark an extension code
   localparam logic [3:0] EXT_LOW    = 4'h0;
   localparam logic [3:0] EXT_HIGH   = 4'hf;

   // Bus answer: one wait cycle, data in the second cycle
   localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

endpackage

/* File: bus_status_top.sv */
// Top of the two-channel bus status block with Avalon-MM slave.
// Function
// - Status register is read only, readable as a byte or single bits.
// - Reset clears status bits 7..4, start and stop of both channels; tx and ack follow their inputs.
// - Bits 7..0: master, arb lost, ext code, addr match, tx, ack, start, stop.
// - Master flag sets when this interface generates a start condition.
// - Master clears on stop, arb loss, exit request, enable fall, reset.
// - Arbitration lost sets on loss and clears master at same time.
// - Arbitration lost clears after status read, enable fall, reset.
// - Arbitration lost clears on single-bit access to another status bit.
// - Extension flag sets at eighth clock if upper nibble 0000 or 1111.
// - Address match sets at eighth clock when address equals slave address.
// - Ext and match clear on start, stop, exit, enable fall, reset.
// Assumes the serial engine supplies one-cycle event pulses per channel.
`timescale 1ns/1ps
`default_nettype none
module bus_status_top #(
   parameter int CHANNELS = 2
) (
   input  wire logic        REF_CLK,
   input  wire logic        ARST_N,
   input  wire logic [5:0]  AVS_ADDRESS,
   input  wire logic        AVS_READ,
   input  wire logic        AVS_WRITE,
   input  wire logic [31:0] AVS_WRITEDATA,
   input  wire logic [3:0]  AVS_BYTEENABLE,
   output logic [31:0]      AVS_READDATA,
   output logic             AVS_WAITREQUEST,
   input  wire logic [1:0]  START_GEN,
   input  wire logic [1:0]  START_SEEN,
   input  wire logic [1:0]  STOP_SEEN,
   input  wire logic [1:0]  ARB_LOST,
   input  wire logic [1:0]  CLK8_RISE,
   input  wire logic [15:0] ADDR_BYTE,
   input  wire logic [1:0]  TX_DIR,
   input  wire logic [1:0]  ACK_DET,
   input  wire logic [1:0]  WAIT_ACTIVE,
   output logic [1:0]       INTERFACE_ENABLE,
   output logic [1:0]       START_TRIGGER,
   output logic [1:0]       EXIT_COMMUNICATION,
   output logic             IRQ
);
   // The register map holds exactly two channels
   if (CHANNELS != 2) begin : g_bad_channels
      $error("Only two channels are supported");
   end

   // ==========================================================
   // Bus handshake: waitrequest high in first cycle, low in second
   logic        ack_q;
   logic        waitreq_q;
   logic [31:0] rdata_q;
   logic [7:0]  ctrl_q   [2];
   logic [6:0]  saddr_q  [2];
   logic [3:0]  bitsel_q;
   logic [3:0]  irq_st_q, irq_mask_q;
   logic [1:0]  start_q, stop_q, exit_q;
   logic        irq_q;

   wire access    = (AVS_READ | AVS_WRITE) & ~ack_q;
   wire done      = (AVS_READ | AVS_WRITE) & ack_q;
   wire rd_done   = AVS_READ & ack_q;
   wire wr_done   = AVS_WRITE & ack_q & AVS_BYTEENABLE[0];
   wire [7:0] wd  = AVS_WRITEDATA[7:0];

   wire [7:0] status [2];
   status_flag_if sfi [2] ();

   // ==========================================================
   // Per-channel flag logic and event decode
   genvar c;
   generate
      for (c = 0; c < 2; c++) begin : g_ch
         wire [5:0] st_ofs = (c == 1) ? bus_status_pkg::OFS_STATUS_CH1
                                      : bus_status_pkg::OFS_STATUS_CH0;
         wire [5:0] ct_ofs = (c == 1) ? bus_status_pkg::OFS_CTRL_CH1
                                      : bus_status_pkg::OFS_CTRL_CH0;
         wire [5:0] sa_ofs = (c == 1) ? bus_status_pkg::OFS_SADDR_CH1
                                      : bus_status_pkg::OFS_SADDR_CH0;
         wire en_now  = ctrl_q[c][bus_status_pkg::CTL_ENABLE];
         wire ctl_wr  = wr_done & (AVS_ADDRESS == ct_ofs);
         wire en_fall = en_now & ctl_wr & ~wd[bus_status_pkg::CTL_ENABLE];
         wire exit_w  = ctl_wr & wd[bus_status_pkg::CTL_EXIT];
         wire byte_rd = rd_done & (AVS_ADDRESS == st_ofs);
         wire bit_rd  = rd_done & (AVS_ADDRESS == bus_status_pkg::OFS_BITREAD)
                        & (bitsel_q[bus_status_pkg::BR_CH] == 1'(c));
         wire other   = bit_rd & (bitsel_q[2:0] !=
                                  3'(bus_status_pkg::BIT_ARBLOST));

         assign sfi[c].start_gen    = START_GEN[c];
         assign sfi[c].start_seen   = START_SEEN[c];
         assign sfi[c].stop_seen    = STOP_SEEN[c];
         assign sfi[c].arb_lost_ev  = ARB_LOST[c];
         assign sfi[c].clk8_rise    = CLK8_RISE[c];
         assign sfi[c].addr_byte    = ADDR_BYTE[8*c +: 8];
         assign sfi[c].slave_addr   = saddr_q[c];
         assign sfi[c].exit_req     = exit_w;
         assign sfi[c].enable_fall  = en_fall;
         assign sfi[c].read_clear   = byte_rd;
         assign sfi[c].bit_op_other = other;

         status_flags u_flags (
            .clk    (REF_CLK),
            .arst_n (ARST_N),
            .sf     (sfi[c])
         );

         assign status[c] = {sfi[c].status_hi, TX_DIR[c], ACK_DET[c],
                             start_q[c], stop_q[c]};

         always_ff @(posedge REF_CLK or negedge ARST_N) begin
            if (!ARST_N) begin
               ctrl_q[c]  <= bus_status_pkg::CTRL_RST;
               saddr_q[c] <= bus_status_pkg::SADDR_RST[6:0];
               start_q[c] <= 1'b0;
               stop_q[c]  <= 1'b0;
               exit_q[c]  <= 1'b0;
            end else begin
               if (ctl_wr) begin
                  ctrl_q[c] <= {wd[7:3], 1'b0, wd[1:0]};
               end else if (START_GEN[c] | ARB_LOST[c]) begin
                  ctrl_q[c][bus_status_pkg::CTL_START] <= 1'b0;
               end
               if (wr_done & (AVS_ADDRESS == sa_ofs)) begin
                  saddr_q[c] <= wd[7:1];
               end
               start_q[c] <= START_SEEN[c] | (start_q[c] & ~STOP_SEEN[c]);
               stop_q[c]  <= STOP_SEEN[c] | (stop_q[c] & ~START_SEEN[c]);
               exit_q[c]  <= exit_w;
            end
         end
      end
   endgenerate

   // ==========================================================
   // Read mux; snapshot taken in the wait cycle, shown in the answering cycle
   wire [3:0] irq_ev = {CLK8_RISE[1] & (ADDR_BYTE[15:9] == saddr_q[1]),
                        ARB_LOST[1],
                        CLK8_RISE[0] & (ADDR_BYTE[7:1] == saddr_q[0]),
                        ARB_LOST[0]};
   wire [7:0] bit_src = status[bitsel_q[bus_status_pkg::BR_CH]];
   logic [31:0] rmux;
   always_comb begin
      unique case (AVS_ADDRESS)
         bus_status_pkg::OFS_STATUS_CH0: rmux = {24'h0, status[0]};
         bus_status_pkg::OFS_STATUS_CH1: rmux = {24'h0, status[1]};
         bus_status_pkg::OFS_CTRL_CH0:   rmux = {24'h0, ctrl_q[0]};
         bus_status_pkg::OFS_CTRL_CH1:   rmux = {24'h0, ctrl_q[1]};
         bus_status_pkg::OFS_SADDR_CH0:  rmux = {24'h0, saddr_q[0], 1'b0};
         bus_status_pkg::OFS_SADDR_CH1:  rmux = {24'h0, saddr_q[1], 1'b0};
         bus_status_pkg::OFS_BITREAD:    rmux = {31'h0, bit_src[bitsel_q[2:0]]};
         bus_status_pkg::OFS_IRQ_STATUS: rmux = {28'h0, irq_st_q};
         bus_status_pkg::OFS_IRQ_MASK:   rmux = {28'h0, irq_mask_q};
         default:                        rmux = bus_status_pkg::UNMAPPED_DATA;
      endcase
   end

   // ==========================================================
   // Bus, bit selector and interrupt registers
   wire irq_st_wr  = wr_done & (AVS_ADDRESS == bus_status_pkg::OFS_IRQ_STATUS);
   wire [3:0] irq_st_d = irq_ev | (irq_st_q & ~(irq_st_wr ? wd[3:0] : 4'h0));

   always_ff @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         ack_q      <= 1'b0;
         waitreq_q  <= 1'b1;
         rdata_q    <= 32'h0;
         bitsel_q   <= 4'h0;
         irq_st_q   <= bus_status_pkg::IRQ_RST;
         irq_mask_q <= bus_status_pkg::IRQ_RST;
         irq_q      <= 1'b0;
      end else begin
         ack_q    <= access;
         waitreq_q <= ~access;
         rdata_q  <= access & AVS_READ ? rmux : rdata_q;
         irq_st_q <= irq_st_d;
         irq_q    <= |(irq_st_d & irq_mask_q);
         if (wr_done & (AVS_ADDRESS == bus_status_pkg::OFS_IRQ_MASK)) begin
            irq_mask_q <= wd[3:0];
         end
         if (wr_done & (AVS_ADDRESS == bus_status_pkg::OFS_BITREAD)) begin
            bitsel_q <= wd[3:0];
         end
      end
   end

   // Status registers have no write path
   assign AVS_READDATA       = rdata_q;
   assign AVS_WAITREQUEST    = waitreq_q;
   assign IRQ                = irq_q;
   assign INTERFACE_ENABLE   = {ctrl_q[1][0], ctrl_q[0][0]};
   assign START_TRIGGER      = {ctrl_q[1][1], ctrl_q[0][1]};
   assign EXIT_COMMUNICATION = exit_q;

   // ==========================================================
   // Checks
   sequence s_read_status0;
      rd_done && AVS_ADDRESS == bus_status_pkg::OFS_STATUS_CH0;
   endsequence
   property p_read_clears_arb;
      @(posedge REF_CLK) disable iff (!ARST_N)
      (s_read_status0 ##0 !ARB_LOST[0]) |=> !status[0][6];
   endproperty
   a_read_clears_arb: assert property (p_read_clears_arb)
      else $error("Arbitration lost not cleared by read");

   property p_snapshot;
      @(posedge REF_CLK) disable iff (!ARST_N)
      (access && AVS_READ && AVS_ADDRESS == bus_status_pkg::OFS_STATUS_CH0)
      |=> (AVS_READDATA[7:0] == $past(status[0]));
   endproperty
   a_snapshot: assert property (p_snapshot)
      else $error("Status read data does not match snapshot");

   property p_start_master;
      @(posedge REF_CLK) disable iff (!ARST_N)
      START_GEN[1] |=> status[1][7];
   endproperty
   a_start_master: assert property (p_start_master)
      else $error("Start generation did not set master flag");

   property p_ext_set;
      @(posedge REF_CLK) disable iff (!ARST_N)
      (CLK8_RISE[0] && ADDR_BYTE[7:4] == 4'hf) |=> status[0][5];
   endproperty
   a_ext_set: assert property (p_ext_set)
      else $error("Extension code not flagged");

   property p_match_set;
      @(posedge REF_CLK) disable iff (!ARST_N)
      (CLK8_RISE[0] && ADDR_BYTE[7:1] == saddr_q[0]) |=> status[0][4];
   endproperty
   a_match_set: assert property (p_match_set)
      else $error("Address match not flagged");

   property p_stop_master;
      @(posedge REF_CLK) disable iff (!ARST_N)
      (STOP_SEEN[0] && !START_GEN[0]) |=> !status[0][7];
   endproperty
   a_stop_master: assert property (p_stop_master)
      else $error("Stop did not clear master flag");

   property p_bit_read;
      @(posedge REF_CLK) disable iff (!ARST_N)
      (access && AVS_READ && AVS_ADDRESS == bus_status_pkg::OFS_BITREAD &&
       bitsel_q == 4'h6) |=> AVS_READDATA == {31'h0, $past(status[0][6])};
   endproperty
   a_bit_read: assert property (p_bit_read)
      else $error("Single-bit read returned the wrong bit");

   property p_bit_other_clears;
      @(posedge REF_CLK) disable iff (!ARST_N)
      (rd_done && AVS_ADDRESS == bus_status_pkg::OFS_BITREAD &&
       bitsel_q == 4'h7 && !ARB_LOST[0]) |=> !status[0][6];
   endproperty
   a_bit_other_clears: assert property (p_bit_other_clears)
      else $error("Bit read of another bit kept arbitration lost");

   property p_enable_fall;
      @(posedge REF_CLK) disable iff (!ARST_N)
      (wr_done && AVS_ADDRESS == bus_status_pkg::OFS_CTRL_CH0 &&
       ctrl_q[0][bus_status_pkg::CTL_ENABLE] &&
       !AVS_WRITEDATA[bus_status_pkg::CTL_ENABLE] && !START_GEN[0])
      |=> !status[0][7];
   endproperty
   a_enable_fall: assert property (p_enable_fall)
      else $error("Enable fall did not clear master flag");

   property p_stop_match;
      @(posedge REF_CLK) disable iff (!ARST_N)
      (STOP_SEEN[1] && !CLK8_RISE[1]) |=> !status[1][4];
   endproperty
   a_stop_match: assert property (p_stop_match)
      else $error("Stop did not clear address match flag");

   property p_exit_pulse;
      @(posedge REF_CLK) disable iff (!ARST_N)
      (wr_done && AVS_ADDRESS == bus_status_pkg::OFS_CTRL_CH1 &&
       AVS_WRITEDATA[bus_status_pkg::CTL_EXIT]) |=> EXIT_COMMUNICATION[1];
   endproperty
   a_exit_pulse: assert property (p_exit_pulse)
      else $error("Exit request did not reach its output");

   property p_irq_level;
      @(posedge REF_CLK) disable iff (!ARST_N)
      $stable(irq_mask_q) |-> (IRQ == |(irq_st_q & irq_mask_q));
   endproperty
   a_irq_level: assert property (p_irq_level)
      else $error("Interrupt output disagrees with status and mask");

   property p_trigger_drop;
      @(posedge REF_CLK) disable iff (!ARST_N)
      (START_GEN[0] && !(wr_done && AVS_ADDRESS ==
       bus_status_pkg::OFS_CTRL_CH0)) |=> !START_TRIGGER[0];
   endproperty
   a_trigger_drop: assert property (p_trigger_drop)
      else $error("Start generation did not drop the start trigger");

   property p_one_wait;
      @(posedge REF_CLK) disable iff (!ARST_N)
      done |-> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
   endproperty
   a_one_wait: assert property (p_one_wait)
      else $error("Wait request not low for exactly the answer cycle");
endmodule
`default_nettype wire

/* File: engine_model.sv */
// Behavioural model of the serial engine that feeds the status block.
// Assumes its tasks are called just after a rising edge of clk.
`timescale 1ns/1ps
`default_nettype none
module engine_model (
   input  wire logic        clk,
   output logic [1:0]       start_gen,
   output logic [1:0]       start_seen,
   output logic [1:0]       stop_seen,
   output logic [1:0]       arb_lost,
   output logic [1:0]       clk8_rise,
   output logic [15:0]      addr_byte,
   output logic [1:0]       tx_dir,
   output logic [1:0]       ack_det,
   output logic [1:0]       wait_active
);
   logic [1:0] ev_q [5];

   assign start_gen  = ev_q[0];
   assign start_seen = ev_q[1];
   assign stop_seen  = ev_q[2];
   assign arb_lost   = ev_q[3];
   assign clk8_rise  = ev_q[4];

   initial begin
      for (int i = 0; i < 5; i++) begin
         ev_q[i] = 2'h0;
      end
      addr_byte   = 16'h0000;
      tx_dir      = 2'h0;
      ack_det     = 2'h0;
      wait_active = 2'h3;
   end

   // ==========================================================
   // One-cycle event; address byte is valid only with its pulse
   task pulse(input int k, input int ch, input logic [7:0] a);
      addr_byte[8*ch +: 8] <= a;
      ev_q[k][ch]          <= 1'b1;
      @(posedge clk);
      ev_q[k][ch]          <= 1'b0;
      addr_byte[8*ch +: 8] <= ~a;
      @(posedge clk);
   endtask

   task levels(input logic [1:0] t, input logic [1:0] a);
      tx_dir  <= t;
      ack_det <= a;
   endtask
endmodule
`default_nettype wire

/* File: status_flag_if.sv */
// Interface carrying one channel's events and flags between modules.
// Assumes both ends share the REF_CLK domain.
`timescale 1ns/1ps
`default_nettype none
interface status_flag_if;
   logic       start_gen;
   logic       start_seen;
   logic       stop_seen;
   logic       arb_lost_ev;
   logic       clk8_rise;
   logic [7:0] addr_byte;
   logic [6:0] slave_addr;
   logic       exit_req;
   logic       enable_fall;
   logic       read_clear;
   logic       bit_op_other;
   logic [3:0] status_hi;

   modport ctrl (output start_gen, start_seen, stop_seen, arb_lost_ev,
                 clk8_rise, addr_byte, slave_addr, exit_req,
                 enable_fall, read_clear, bit_op_other,
                 input status_hi);
   modport flags (input start_gen, start_seen, stop_seen, arb_lost_ev,
                  clk8_rise, addr_byte, slave_addr, exit_req,
                  enable_fall, read_clear, bit_op_other,
                  output status_hi);
endinterface
`default_nettype wire

/* File: status_flags.sv */
// One channel's upper four status flags: master, arbitration lost,
// extension code and address match. Assumes one-cycle event pulses.
`timescale 1ns/1ps
`default_nettype none
module status_flags (
   input  wire logic     clk,
   input  wire logic     arst_n,
   status_flag_if.flags  sf
);
   logic master_q,  master_d;
   logic arblost_q, arblost_d;
   logic extcode_q, extcode_d;
   logic addrmat_q, addrmat_d;

   wire common_clr = sf.exit_req | sf.enable_fall;
   wire ext_hit    = sf.clk8_rise &
                     ((sf.addr_byte[7:4] == bus_status_pkg::EXT_LOW) |
                      (sf.addr_byte[7:4] == bus_status_pkg::EXT_HIGH));
   wire addr_hit   = sf.clk8_rise & (sf.addr_byte[7:1] == sf.slave_addr);
   wire ea_clr     = sf.start_seen | sf.stop_seen | common_clr;

   // ==========================================================
   // Next-state: the set event wins over a clear in the same cycle
   assign master_d  = sf.start_gen ? 1'b1 :
                      (sf.stop_seen | sf.arb_lost_ev | common_clr)
                      ? 1'b0 : master_q;
   assign arblost_d = sf.arb_lost_ev ? 1'b1 :
                      (sf.read_clear | sf.bit_op_other |
                       sf.enable_fall) ? 1'b0 : arblost_q;
   assign extcode_d = ext_hit  ? 1'b1 : ea_clr ? 1'b0 : extcode_q;
   assign addrmat_d = addr_hit ? 1'b1 : ea_clr ? 1'b0 : addrmat_q;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         master_q  <= 1'b0;
         arblost_q <= 1'b0;
         extcode_q <= 1'b0;
         addrmat_q <= 1'b0;
      end else begin
         master_q  <= master_d;
         arblost_q <= arblost_d;
         extcode_q <= extcode_d;
         addrmat_q <= addrmat_d;
      end
   end

   assign sf.status_hi = {master_q, arblost_q, extcode_q, addrmat_q};

   // ==========================================================
   // Checks
   property p_arb_drops_master;
      @(posedge clk) disable iff (!arst_n)
      (sf.arb_lost_ev && !sf.start_gen) |=> (!master_q && arblost_q);
   endproperty
   a_arb_drops_master: assert property (p_arb_drops_master)
      else $error("Arbitration loss did not drop master flag");

   property p_ext_clear;
      @(posedge clk) disable iff (!arst_n)
      (ea_clr && !ext_hit) |=> !extcode_q;
   endproperty
   a_ext_clear: assert property (p_ext_clear)
      else $error("Extension flag survived a clear event");
endmodule
`default_nettype wire

/* File: tb_top.sv */
// Self-checking bench for the bus status block over Avalon-MM.
// Assumes engine_model stands in for the serial engine.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic        ref_clk         = 1'b0;
   logic        arst_n          = 1'b0;
   logic [5:0]  avs_address     = 6'h00;
   logic        avs_read        = 1'b0;
   logic        avs_write       = 1'b0;
   logic [31:0] avs_writedata   = 32'h0;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic [1:0]  start_gen, start_seen, stop_seen, arb_lost, clk8_rise;
   logic [1:0]  tx_dir, ack_det, wait_active, if_enable, st_trig;
   logic [15:0] addr_byte;
   logic        irq;
   logic [31:0] rd;
   logic [7:0]  ext_a [4] = '{8'h0a, 8'hf1, 8'h5a, 8'he0};
   logic        ext_e [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
   int          n_fail = 0;
   int          samples_checked = 0;

   always #20 ref_clk = ~ref_clk;

   engine_model engine_u (.clk(ref_clk), .start_gen(start_gen),
      .start_seen(start_seen), .stop_seen(stop_seen), .arb_lost(arb_lost),
      .clk8_rise(clk8_rise), .addr_byte(addr_byte), .tx_dir(tx_dir),
      .ack_det(ack_det), .wait_active(wait_active));

   bus_status_top #(.CHANNELS(2)) dut_u (.REF_CLK(ref_clk), .ARST_N(arst_n),
      .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
      .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata),
      .AVS_BYTEENABLE(4'hf), .AVS_READDATA(avs_readdata),
      .AVS_WAITREQUEST(avs_waitrequest), .START_GEN(start_gen),
      .START_SEEN(start_seen), .STOP_SEEN(stop_seen), .ARB_LOST(arb_lost),
      .CLK8_RISE(clk8_rise), .ADDR_BYTE(addr_byte), .TX_DIR(tx_dir),
      .ACK_DET(ack_det), .WAIT_ACTIVE(wait_active),
      .INTERFACE_ENABLE(if_enable), .START_TRIGGER(st_trig),
      .EXIT_COMMUNICATION(), .IRQ(irq));

   // ==========================================================
   // Reporting
   task automatic finish_test;
      $display("checked %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input logic [31:0] m);
      samples_checked++;
      if ((got & m) !== (exp & m)) begin
         n_fail++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask

   // ==========================================================
   // Avalon-MM master: hold request until waitrequest is seen low
   task automatic bus(input logic wr, input logic [5:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      avs_address   <= a;
      avs_write     <= wr;
      avs_read      <= ~wr;
      avs_writedata <= d;
      do begin
         @(posedge ref_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 16);
      rd = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
      if (avs_waitrequest !== 1'b0) begin
         n_fail++;
         $display("unexpected at %0t: bus access timed out", $time);
         finish_test();
      end else begin
         @(posedge ref_clk);
      end
   endtask

   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      bus(1'b1, a, {24'h0, d});
   endtask

   task automatic rd_chk(input logic [5:0] a, input logic [7:0] e,
                         input logic [7:0] m);
      bus(1'b0, a, 32'h0);
      chk(rd, {24'h0, e}, {24'hffffff, m});
   endtask

   task automatic irq_chk(input logic e);
      repeat (2) @(posedge ref_clk);
      chk({31'h0, irq}, {31'h0, e}, 32'h1);
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      repeat (16) @(posedge ref_clk);
      arst_n <= 1'b1;
      @(posedge ref_clk);
      rd_chk(bus_status_pkg::OFS_STATUS_CH0, 8'h00, 8'hff);
      rd_chk(bus_status_pkg::OFS_STATUS_CH1, 8'h00, 8'hff);
      rd_chk(6'h3c, 8'h00, 8'hff);
      wr(bus_status_pkg::OFS_STATUS_CH0, 8'hff);
      rd_chk(bus_status_pkg::OFS_STATUS_CH0, 8'h00, 8'hff);
      wr(bus_status_pkg::OFS_CTRL_CH0, 8'h03);
      chk({31'h0, if_enable[0]}, 32'h1, 32'h1);
      chk({31'h0, st_trig[0]}, 32'h1, 32'h1);
      engine_u.levels(2'b01, 2'b01);
      engine_u.pulse(0, 0, 8'h00);
      rd_chk(bus_status_pkg::OFS_STATUS_CH0, 8'h8c, 8'hfc);
      chk({31'h0, st_trig[0]}, 32'h0, 32'h1);
      engine_u.levels(2'b00, 2'b00);
      engine_u.pulse(3, 0, 8'h00);
      rd_chk(bus_status_pkg::OFS_STATUS_CH0, 8'h40, 8'hf0);
      rd_chk(bus_status_pkg::OFS_STATUS_CH0, 8'h00, 8'hf0);
      // Masked, then unmasked, then cleared interrupt
      engine_u.pulse(3, 0, 8'h00);
      irq_chk(1'b0);
      rd_chk(bus_status_pkg::OFS_IRQ_STATUS, 8'h01, 8'h01);
      wr(bus_status_pkg::OFS_IRQ_MASK, 8'h01);
      irq_chk(1'b1);
      wr(bus_status_pkg::OFS_IRQ_STATUS, 8'h01);
      irq_chk(1'b0);
      // Single-bit reads: own bit keeps the flag, another bit clears it
      wr(bus_status_pkg::OFS_BITREAD, 8'h06);
      rd_chk(bus_status_pkg::OFS_BITREAD, 8'h01, 8'h01);
      wr(bus_status_pkg::OFS_BITREAD, 8'h07);
      rd_chk(bus_status_pkg::OFS_BITREAD, 8'h00, 8'h01);
      rd_chk(bus_status_pkg::OFS_STATUS_CH0, 8'h00, 8'h40);
      for (int i = 0; i < 4; i++) begin
         engine_u.pulse(4, 0, ext_a[i]);
         rd_chk(bus_status_pkg::OFS_STATUS_CH0, {2'b00, ext_e[i], 5'h0},
                8'h20);
         engine_u.pulse(1, 0, 8'h00);
         rd_chk(bus_status_pkg::OFS_STATUS_CH0, 8'h00, 8'h20);
      end
      wr(bus_status_pkg::OFS_CTRL_CH1, 8'h01);
      wr(bus_status_pkg::OFS_SADDR_CH1, 8'h54);
      engine_u.pulse(4, 1, 8'h57);
      rd_chk(bus_status_pkg::OFS_STATUS_CH1, 8'h00, 8'h10);
      for (int m = 0; m < 2; m++) begin
         engine_u.pulse(4, 1, 8'h55);
         rd_chk(bus_status_pkg::OFS_STATUS_CH1, 8'h10, 8'h30);
         if (m == 0) begin
            engine_u.pulse(2, 1, 8'h00);
         end else begin
            wr(bus_status_pkg::OFS_CTRL_CH1, 8'h05);
         end
         rd_chk(bus_status_pkg::OFS_STATUS_CH1, 8'h00, 8'h30);
      end
      for (int m = 0; m < 3; m++) begin
         wr(bus_status_pkg::OFS_CTRL_CH0, 8'h03);
         engine_u.pulse(0, 0, 8'h00);
         rd_chk(bus_status_pkg::OFS_STATUS_CH0, 8'h80, 8'h80);
         case (m)
            0: engine_u.pulse(2, 0, 8'h00);
            1: wr(bus_status_pkg::OFS_CTRL_CH0, 8'h00);
            default: wr(bus_status_pkg::OFS_CTRL_CH0, 8'h05);
         endcase
         rd_chk(bus_status_pkg::OFS_STATUS_CH0, 8'h00, 8'h80);
      end
      // Reset in mid-run with flags set on both channels
      engine_u.pulse(0, 1, 8'h00);
      rd_chk(bus_status_pkg::OFS_STATUS_CH1, 8'h80, 8'h80);
      engine_u.pulse(1, 0, 8'h00);
      arst_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      arst_n <= 1'b1;
      @(posedge ref_clk);
      chk({30'h0, if_enable}, 32'h0, 32'h3);
      rd_chk(bus_status_pkg::OFS_STATUS_CH0, 8'h00, 8'hff);
      rd_chk(bus_status_pkg::OFS_STATUS_CH1, 8'h00, 8'hff);
      finish_test();
   end
endmodule
`default_nettype wire
